// File: logic/css_bridge.sv
// one bidirectional host/card line bridge with edge arbitration
`timescale 1ns/100ps
`default_nettype none
`include "css_map.svh"
module css_bridge #(
  parameter int DELAY_CYCLES = (`CSS_EDGE_DELAY_NS * `CSS_CLK_MHZ) / 1000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic enable,
  input wire logic ground,
  // host side line
  input wire logic hostIn,
  output logic hostOut,
  output logic hostOe,
  // card side line
  input wire logic cardIn,
  output logic cardOut,
  output logic cardOe
);
  logic hostMeta, hostSync, hostPrev, cardMeta, cardSync, cardPrev;
  logic masterHost_reg;
  logic [7:0] delayCnt_reg;
  css_pkg::css_bridge_state_t state_reg;
  logic masterLevel;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hostMeta <= 1'h1;
      hostSync <= 1'h1;
      hostPrev <= 1'h1;
      cardMeta <= 1'h1;
      cardSync <= 1'h1;
      cardPrev <= 1'h1;
    end else begin
      hostMeta <= hostIn;
      hostSync <= hostMeta;
      hostPrev <= hostSync;
      cardMeta <= cardIn;
      cardSync <= cardMeta;
      cardPrev <= cardSync;
    end
  end

  assign masterLevel = masterHost_reg ? hostSync : cardSync;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= css_pkg::BR_IDLE;
      masterHost_reg <= 1'h0;
      delayCnt_reg <= 8'h00;
    end else if (!enable || ground) begin
      state_reg <= css_pkg::BR_IDLE;
      delayCnt_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        css_pkg::BR_IDLE: begin
          delayCnt_reg <= 8'h00;
          // host wins a simultaneous fall; the slave's edges are not looked at after this
          if (hostPrev && !hostSync) begin
            masterHost_reg <= 1'h1;
            state_reg <= css_pkg::BR_WAIT;
          end else if (cardPrev && !cardSync) begin
            masterHost_reg <= 1'h0;
            state_reg <= css_pkg::BR_WAIT;
          end
        end
        css_pkg::BR_WAIT: begin
          delayCnt_reg <= delayCnt_reg + 8'h01;
          if (masterLevel) begin
            state_reg <= css_pkg::BR_IDLE;
          end else if (delayCnt_reg == 8'(DELAY_CYCLES - 1)) begin
            state_reg <= css_pkg::BR_LOW;
          end
        end
        css_pkg::BR_LOW: begin
          delayCnt_reg <= 8'h00;
          if (masterLevel) begin
            state_reg <= css_pkg::BR_HIGH;
          end
        end
        css_pkg::BR_HIGH: begin
          delayCnt_reg <= delayCnt_reg + 8'h01;
          if (delayCnt_reg == 8'(DELAY_CYCLES - 1)) begin
            state_reg <= css_pkg::BR_IDLE;
          end
        end
      endcase
    end
  end

  // idle leaves both lines to their pull-ups; grounding pulls only the card side
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hostOut <= 1'h1;
      hostOe <= 1'h0;
      cardOut <= 1'h0;
      cardOe <= 1'h1;
    end else begin
      hostOut <= (state_reg == css_pkg::BR_HIGH);
      cardOut <= !ground && (state_reg == css_pkg::BR_HIGH);
      hostOe <= !ground && !masterHost_reg &&
                (state_reg == css_pkg::BR_LOW || state_reg == css_pkg::BR_HIGH);
      cardOe <= ground || (masterHost_reg &&
                (state_reg == css_pkg::BR_LOW || state_reg == css_pkg::BR_HIGH));
    end
  end

  one_side_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(hostOe && cardOe)) else $error("bridge drives both sides");
  slave_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == css_pkg::BR_LOW && !ground && enable) |=> (hostOe || cardOe) &&
    !hostOut && !cardOut) else $error("slave not driven low");
endmodule : css_bridge
`default_nettype wire

// File: logic/css_map.svh
// constants of the card session sequencer
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH

`define CSS_CLK_MHZ 100
`define CSS_POR_PULSE_MS 10
`define CSS_EDGE_DELAY_NS 200
`define CSS_T_OSC_PERIODS 64
`define CSS_HALF_T_LAST 5'h1f

`define CSS_AXI_AW 8
`define CSS_ADDR_CTRL 8'h00
`define CSS_ADDR_STATUS 8'h04
`define CSS_CTRL_HOLD_BIT 0
`define CSS_CTRL_RESET 1'h0
`define CSS_RESP_OKAY 2'h0
`define CSS_RESP_SLVERR 2'h2

`define CSS_ST_STATE_LO 0
`define CSS_ST_CARD_PRESENCE_IN_BIT 3
`define CSS_ST_FAULT_BIT 4
`define CSS_ST_RATIO_LO 5
`define CSS_ST_CLKRUN_BIT 7

`define CSS_DIV_BY8 2'h0
`define CSS_DIV_BY4 2'h1
`define CSS_DIV_BY2 2'h3
`define CSS_DIV_BY1 2'h2

`define CSS_HA_SUPPLY 4'h1
`define CSS_HA_BRIDGE 4'h8
`define CSS_HA_RSTEN 4'he
`define CSS_HD_CLKSTOP 4'h1
`define CSS_HD_BRIDGEOFF 4'h2
`define CSS_HD_SUPPLYOFF 4'h3
`define CSS_HD_DONE 4'ha

`endif

// File: logic/css_pkg.sv
// types of the card session sequencer
`include "css_map.svh"
package css_pkg;
  typedef enum logic [2:0] {
    ST_OFFLINE, ST_INACTIVE, ST_ACTIVATING, ST_ACTIVE, ST_DEACTIVATING
  } css_state_t;

  typedef enum logic [1:0] {BR_IDLE, BR_WAIT, BR_LOW, BR_HIGH} css_bridge_state_t;

  typedef struct packed {
    logic awvalid;
    logic [`CSS_AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`CSS_AXI_AW-1:0] araddr;
    logic rready;
  } css_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } css_axil_rsp_t;
endpackage : css_pkg

// File: logic/css_sequencer.sv
// card session sequencer: supervisor, card clock divider, bridges, sequencing, AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
`include "css_map.svh"
module css_sequencer #(
  parameter int POR_CYCLES = `CSS_POR_PULSE_MS * 1000 * 1000 * `CSS_CLK_MHZ / 1000,
  parameter int EDGE_CYCLES = (`CSS_EDGE_DELAY_NS * `CSS_CLK_MHZ) / 1000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register bus
  input wire css_pkg::css_axil_req_t axiReq,
  output css_pkg::css_axil_rsp_t axiRsp,
  // supply supervisor comparators
  input wire logic supplyAboveHigh,
  input wire logic supplyBelowLow,
  // host control pins
  input wire logic sessionRequestN,
  input wire logic hostResetIn,
  input wire logic clockDivideSel1,
  input wire logic clockDivideSel2,
  input wire logic oscillatorIn,
  output logic faultPresenceN,
  // card sense inputs
  input wire logic cardPresenceN,
  input wire logic cardPresenceIn,
  input wire logic vccOverload,
  input wire logic overTemp,
  // card power and control
  output logic boosterOutput,
  output logic cardSupplyOn,
  output logic cardClk,
  output logic cardReset,
  // bridged lines: bit 0 data, bit 1 aux a, bit 2 aux b
  input wire logic [2:0] hostLineIn,
  output logic [2:0] hostLineOut,
  output logic [2:0] hostLineOe,
  input wire logic [2:0] cardLineIn,
  output logic [2:0] cardLineOut,
  output logic [2:0] cardLineOe
);
  localparam int HALF_T_OSC = `CSS_T_OSC_PERIODS / 2;

  // two-stage synchronisers for every supervisor, host control and card sense pin
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] pinRaw, pinMeta, pinSync;
  assign pinRaw = {supplyAboveHigh, supplyBelowLow, sessionRequestN, hostResetIn,
                   clockDivideSel1, clockDivideSel2, oscillatorIn, cardPresenceN,
                   cardPresenceIn, vccOverload, overTemp};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
    end
  end
  logic supHigh, supLow, sessReqN, hostRst, oscLvl, presN, card_presence_in, overload, hot;
  logic [1:0] selSync;
  assign {supHigh, supLow, sessReqN, hostRst} = pinSync[10:7];
  assign selSync = pinSync[6:5];
  assign {oscLvl, presN, card_presence_in, overload, hot} = pinSync[4:0];

  logic cardPresent, faultNow;
  assign cardPresent = !presN || card_presence_in;
  assign faultNow = !cardPresent || overload || hot;

  // oscillator edges and half-T ticks
  logic oscPrev, oscRise, halfTick;
  logic [4:0] htCnt_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oscPrev <= 1'h0;
    end else begin
      oscPrev <= oscLvl;
    end
  end
  assign oscRise = oscLvl && !oscPrev;
  assign halfTick = oscRise && (htCnt_reg == 5'(HALF_T_OSC - 1));

  // power-on hold counter
  logic [31:0] porCnt_reg;
  logic porBusy;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      porCnt_reg <= 32'h0;
    end else if (!supHigh) begin
      porCnt_reg <= 32'h0;
    end else if (porBusy) begin
      porCnt_reg <= porCnt_reg + 32'h1;
    end
  end
  assign porBusy = (porCnt_reg != 32'(POR_CYCLES));

  // registers
  logic ctrlHold_reg;
  css_pkg::css_state_t state_reg;
  logic faultLatched_reg, clkRun_reg;
  logic [1:0] ratio_reg;

  // sequencer
  logic [3:0] seqCnt_reg;
  logic rstHighAtStart_reg, rstEnabled_reg, bridgesOn_reg, groundCard_reg, hostRstPrev;
  logic startReq, stopReq;
  assign startReq = !sessReqN && cardPresent && !ctrlHold_reg && !porBusy && !supLow;
  assign stopReq = sessReqN || faultLatched_reg || faultNow || supLow || ctrlHold_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      htCnt_reg <= 5'h00;
    end else if (state_reg == css_pkg::ST_INACTIVE || state_reg == css_pkg::ST_ACTIVE) begin
      htCnt_reg <= 5'h00;
    end else if (state_reg == css_pkg::ST_ACTIVATING && stopReq) begin
      htCnt_reg <= 5'h00; // an aborted activation must not shorten the first T/2
    end else if (oscRise) begin
      htCnt_reg <= (htCnt_reg == `CSS_HALF_T_LAST) ? 5'h00 : htCnt_reg + 5'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= css_pkg::ST_OFFLINE;
      seqCnt_reg <= 4'h0;
      boosterOutput <= 1'h0;
      cardSupplyOn <= 1'h0;
      bridgesOn_reg <= 1'h0;
      groundCard_reg <= 1'h1;
      rstEnabled_reg <= 1'h0;
      clkRun_reg <= 1'h0;
      rstHighAtStart_reg <= 1'h0;
      hostRstPrev <= 1'h0;
    end else begin
      hostRstPrev <= hostRst;
      unique case (state_reg)
        css_pkg::ST_OFFLINE: begin
          if (!porBusy) begin
            state_reg <= css_pkg::ST_INACTIVE;
          end
        end
        css_pkg::ST_INACTIVE: begin
          if (porBusy || supLow) begin
            state_reg <= css_pkg::ST_OFFLINE;
          end else if (startReq) begin
            state_reg <= css_pkg::ST_ACTIVATING;
            boosterOutput <= 1'h1;
            groundCard_reg <= 1'h0;
            seqCnt_reg <= 4'h0;
            rstHighAtStart_reg <= hostRst;
          end
        end
        css_pkg::ST_ACTIVATING, css_pkg::ST_ACTIVE: begin
          if (stopReq) begin
            state_reg <= css_pkg::ST_DEACTIVATING;
            seqCnt_reg <= 4'h0;
            rstEnabled_reg <= 1'h0;
          end else if (state_reg == css_pkg::ST_ACTIVATING) begin
            if (halfTick) begin
              seqCnt_reg <= seqCnt_reg + 4'h1;
            end
            if (seqCnt_reg >= `CSS_HA_SUPPLY) begin
              cardSupplyOn <= 1'h1;
            end
            if (seqCnt_reg >= `CSS_HA_BRIDGE) begin
              bridgesOn_reg <= 1'h1;
              if (!rstHighAtStart_reg || (hostRstPrev && !hostRst)) begin
                clkRun_reg <= 1'h1;
              end
            end
            if (seqCnt_reg == `CSS_HA_RSTEN) begin
              rstEnabled_reg <= 1'h1;
              clkRun_reg <= 1'h1;
              state_reg <= css_pkg::ST_ACTIVE;
            end
          end
        end
        css_pkg::ST_DEACTIVATING: begin
          rstEnabled_reg <= 1'h0;
          if (halfTick) begin
            seqCnt_reg <= seqCnt_reg + 4'h1;
          end
          if (seqCnt_reg >= `CSS_HD_CLKSTOP) begin
            clkRun_reg <= 1'h0;
          end
          if (seqCnt_reg >= `CSS_HD_BRIDGEOFF) begin
            bridgesOn_reg <= 1'h0;
          end
          if (seqCnt_reg >= `CSS_HD_SUPPLYOFF) begin
            cardSupplyOn <= 1'h0;
          end
          if (seqCnt_reg == `CSS_HD_DONE) begin
            boosterOutput <= 1'h0;
            groundCard_reg <= 1'h1;
            state_reg <= css_pkg::ST_INACTIVE;
          end
        end
      endcase
    end
  end

  // card reset copies host reset only once enabled
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cardReset <= 1'h0;
    end else begin
      cardReset <= rstEnabled_reg && hostRst && !stopReq;
    end
  end

  // fault memory: set wins over clear, cleared by the host ending the session
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      faultLatched_reg <= 1'h0;
      faultPresenceN <= 1'h0;
    end else begin
      if ((state_reg == css_pkg::ST_ACTIVATING || state_reg == css_pkg::ST_ACTIVE) &&
          faultNow) begin
        faultLatched_reg <= 1'h1;
      end else if (sessReqN) begin
        faultLatched_reg <= 1'h0;
      end
      // a supply drop deactivates but leaves this output alone
      faultPresenceN <= sessReqN ? cardPresent : !(faultLatched_reg || faultNow);
    end
  end

  // card clock divider; new ratio taken at a period boundary, or on every cycle while the clock is stopped
  logic [2:0] divCnt_reg, divLast, divHalf;
  always_comb begin
    divLast = 3'h0;
    divHalf = 3'h0;
    unique case (ratio_reg)
      `CSS_DIV_BY8: begin divLast = 3'h7; divHalf = 3'h3; end
      `CSS_DIV_BY4: begin divLast = 3'h3; divHalf = 3'h1; end
      `CSS_DIV_BY2: begin divLast = 3'h1; divHalf = 3'h0; end
      `CSS_DIV_BY1: begin divLast = 3'h0; divHalf = 3'h0; end
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_reg <= 3'h0;
      cardClk <= 1'h0;
      ratio_reg <= `CSS_DIV_BY8;
    end else if (!clkRun_reg) begin
      divCnt_reg <= 3'h0;
      cardClk <= 1'h0;
      ratio_reg <= selSync;
    end else if (ratio_reg == `CSS_DIV_BY1) begin
      cardClk <= oscLvl;
      if (oscRise) begin
        ratio_reg <= selSync;
      end
    end else if (oscRise) begin
      if (divCnt_reg == divLast) begin
        divCnt_reg <= 3'h0;
        cardClk <= 1'h1;
        ratio_reg <= selSync;
      end else begin
        divCnt_reg <= divCnt_reg + 3'h1;
        if (divCnt_reg == divHalf) begin
          cardClk <= 1'h0;
        end
      end
    end
  end

  // line bridges
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_bridge
      css_bridge #(.DELAY_CYCLES(EDGE_CYCLES)) u_bridge (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .enable(bridgesOn_reg),
        .ground(groundCard_reg),
        .hostIn(hostLineIn[gi]),
        .hostOut(hostLineOut[gi]),
        .hostOe(hostLineOe[gi]),
        .cardIn(cardLineIn[gi]),
        .cardOut(cardLineOut[gi]),
        .cardOe(cardLineOe[gi])
      );
    end
  endgenerate

  // AXI4-Lite slave: one write and one read in flight
  logic awReady_reg, wReady_reg, bValid_reg, arReady_reg, rValid_reg, awHave_reg, wHave_reg;
  logic [`CSS_AXI_AW-1:0] awAddr_reg;
  logic [31:0] wData_reg, rData_reg;
  logic [3:0] wStrb_reg;
  logic [1:0] bResp_reg, rResp_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awReady_reg <= 1'h1;
      wReady_reg <= 1'h1;
      bValid_reg <= 1'h0;
      awHave_reg <= 1'h0;
      wHave_reg <= 1'h0;
      awAddr_reg <= '0;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
      bResp_reg <= `CSS_RESP_OKAY;
      ctrlHold_reg <= `CSS_CTRL_RESET;
    end else begin
      if (awReady_reg && axiReq.awvalid) begin
        awReady_reg <= 1'h0;
        awHave_reg <= 1'h1;
        awAddr_reg <= axiReq.awaddr;
      end
      if (wReady_reg && axiReq.wvalid) begin
        wReady_reg <= 1'h0;
        wHave_reg <= 1'h1;
        wData_reg <= axiReq.wdata;
        wStrb_reg <= axiReq.wstrb;
      end
      if (awHave_reg && wHave_reg && !bValid_reg) begin
        bValid_reg <= 1'h1;
        awHave_reg <= 1'h0;
        wHave_reg <= 1'h0;
        if (awAddr_reg == `CSS_ADDR_CTRL) begin
          bResp_reg <= `CSS_RESP_OKAY;
          if (wStrb_reg[0]) begin
            ctrlHold_reg <= wData_reg[`CSS_CTRL_HOLD_BIT];
          end
        end else begin
          bResp_reg <= (awAddr_reg == `CSS_ADDR_STATUS) ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
        end
      end
      if (bValid_reg && axiReq.bready) begin
        bValid_reg <= 1'h0;
        awReady_reg <= 1'h1;
        wReady_reg <= 1'h1;
      end
    end
  end

  logic [31:0] statusWord;
  always_comb begin
    statusWord = 32'h0;
    statusWord[`CSS_ST_STATE_LO +: 3] = state_reg;
    statusWord[`CSS_ST_CARD_PRESENCE_IN_BIT] = cardPresent;
    statusWord[`CSS_ST_FAULT_BIT] = faultLatched_reg;
    statusWord[`CSS_ST_RATIO_LO +: 2] = ratio_reg;
    statusWord[`CSS_ST_CLKRUN_BIT] = clkRun_reg;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arReady_reg <= 1'h1;
      rValid_reg <= 1'h0;
      rData_reg <= 32'h0;
      rResp_reg <= `CSS_RESP_OKAY;
    end else if (arReady_reg && axiReq.arvalid) begin
      arReady_reg <= 1'h0;
      rValid_reg <= 1'h1;
      rResp_reg <= `CSS_RESP_OKAY;
      if (axiReq.araddr == `CSS_ADDR_CTRL) begin
        rData_reg <= {31'h0, ctrlHold_reg};
      end else if (axiReq.araddr == `CSS_ADDR_STATUS) begin
        rData_reg <= statusWord;
      end else begin
        rData_reg <= 32'h0;
        rResp_reg <= `CSS_RESP_SLVERR;
      end
    end else if (rValid_reg && axiReq.rready) begin
      rValid_reg <= 1'h0;
      arReady_reg <= 1'h1;
    end
  end
  assign axiRsp = '{awready: awReady_reg, wready: wReady_reg, bvalid: bValid_reg,
                    bresp: bResp_reg, arready: arReady_reg, rvalid: rValid_reg,
                    rdata: rData_reg, rresp: rResp_reg};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence startSeen;
    state_reg == css_pkg::ST_INACTIVE && startReq && !porBusy && !supLow;
  endsequence
  por_inactive_a: assert property (!supHigh |=> state_reg != css_pkg::ST_ACTIVATING ||
    $past(state_reg) == css_pkg::ST_ACTIVATING) else $error("start during hold");
  offline_hold_a: assert property (state_reg == css_pkg::ST_OFFLINE |-> !boosterOutput &&
    !cardSupplyOn && !cardClk && !cardReset) else $error("card powered while offline");
  boost_start_a: assert property (startSeen |=> boosterOutput &&
    state_reg == css_pkg::ST_ACTIVATING) else $error("booster not started");
  deact_reset_a: assert property ((state_reg == css_pkg::ST_ACTIVE) && stopReq |=>
    state_reg == css_pkg::ST_DEACTIVATING ##1 !cardReset) else $error("reset not low");
  rst_order_a: assert property ($rose(rstEnabled_reg) |-> bridgesOn_reg && clkRun_reg &&
    $past(seqCnt_reg) == `CSS_HA_RSTEN) else $error("reset enabled out of order");
  clk_stop_a: assert property (!clkRun_reg |=> !cardClk) else $error("clock not stopped");
  ratio_edge_a: assert property ($changed(ratio_reg) && $past(clkRun_reg) &&
    $past(ratio_reg) != `CSS_DIV_BY1 |-> cardClk && divCnt_reg == 3'h0)
    else $error("ratio changed mid-period");
  presence_out_a: assert property (sessReqN ##1 sessReqN |-> faultPresenceN ==
    $past(cardPresent)) else $error("presence not shown");
  fault_hold_a: assert property (faultLatched_reg && !sessReqN |=> faultLatched_reg &&
    !faultPresenceN) else $error("fault memory lost");
  axi_resp_a: assert property ($rose(bValid_reg) |-> $past(awHave_reg) && $past(wHave_reg))
    else $error("write answered early");
endmodule : css_sequencer
`default_nettype wire

// File: testbench/css_card_model.sv
// card side of the bridged lines: pull-ups and a card that can pull its data line
`timescale 1ns/100ps
`default_nettype none
module css_card_model (
  // device side
  input wire logic [2:0] cardLineOut,
  input wire logic [2:0] cardLineOe,
  // card stimulus
  input wire logic cardPull,
  // resolved lines
  output logic [2:0] cardLineIn
);
  // released lines rise on the pull-up, never hold the last value
  always_comb begin
    cardLineIn = cardLineOe & cardLineOut | ~cardLineOe;
    if (cardPull) begin
      cardLineIn[0] = 1'b0; // slow toggles only, well under 1 MHz
    end
  end
endmodule : css_card_model
`default_nettype wire

// File: testbench/css_sequencer_bench.sv
// self-checking bench of the card session sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin nTests++; if ((s) !== (e)) begin errCount++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
`define WT(c) for (t = 0; t < 3000 && !(c); t++) @(posedge ref_clk); \
  if (t == 3000) begin errCount++; giveVerdict(); end
module css_sequencer_bench;
  logic ref_clk = 0, rst_n = 0, sup = 0, reqN = 1, hRst = 0, s1 = 0, s2 = 0, hPull = 0, cPull = 0;
  logic faultN, boost, vcc, cClk, cRst, pIn = 1;
  logic [1:0] osc = 0, r;
  logic [2:0] hOut, hOe, cOut, cOe, cIn;
  logic [31:0] q, x = 32'h9239ee3f;
  css_pkg::css_axil_req_t req = '{wstrb: 4'hf, default: '0};
  css_pkg::css_axil_rsp_t rsp;
  int errCount = 0, nTests = 0, t, p, dv[4] = '{8, 4, 1, 2};
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) osc <= osc + 2'h1;
  css_sequencer #(.POR_CYCLES(50)) uut (.ref_clk, .rst_n, .axiReq(req), .axiRsp(rsp),
    .supplyAboveHigh(sup), .supplyBelowLow(1'b0), .sessionRequestN(reqN), .hostResetIn(hRst),
    .clockDivideSel1(s1), .clockDivideSel2(s2), .oscillatorIn(osc[1]), .faultPresenceN(faultN),
    .cardPresenceN(1'b1), .cardPresenceIn(pIn), .vccOverload(1'b0), .overTemp(1'b0),
    .boosterOutput(boost), .cardSupplyOn(vcc), .cardClk(cClk), .cardReset(cRst),
    .hostLineIn(hOe & hOut | ~hOe & {2'h3, ~hPull}), .hostLineOut(hOut), .hostLineOe(hOe),
    .cardLineIn(cIn), .cardLineOut(cOut), .cardLineOe(cOe));
  css_card_model card (.cardLineOut(cOut), .cardLineOe(cOe), .cardPull(cPull), .cardLineIn(cIn));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  task automatic cy(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cy
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
    req.awvalid <= w;
    req.wvalid <= w;
    req.bready <= w;
    req.arvalid <= !w;
    req.rready <= !w;
    req.awaddr <= a;
    req.araddr <= a;
    req.wdata <= d;
    for (t = 0; t < 50; t++) begin
      @(posedge ref_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.arready) req.arvalid <= 1'b0;
      if (w ? rsp.bvalid : rsp.rvalid) break;
    end
    req.bready <= 1'b0;
    req.rready <= 1'b0;
    q = rsp.rdata;
    r = w ? rsp.bresp : rsp.rresp;
    @(posedge ref_clk); // one edge between calls, so no strobe is set twice in a step
    if (t == 50) begin
      errCount++;
      giveVerdict();
    end
  endtask : axi
  // period of the card clock in ref_clk cycles
  task automatic per(output int n);
    int k;
    logic pc;
    k = 0;
    n = 0;
    pc = cClk;
    for (int i = 0; i < 300 && k < 2; i++) begin
      @(posedge ref_clk);
      if (k) n++;
      if (cClk && !pc) k++;
      pc = cClk;
    end
  endtask : per
  task automatic giveVerdict;
    $display("checks %0d errors %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : giveVerdict
  initial begin
    cy(20);
    rst_n <= 1'b1;
    sup <= 1'b1;
    cy(80); // supervisor hold time over before any request
    axi(0, 8'h04, 0);
    `CHK("state", 32'h1, q & 32'h7)
    `CHK("present", 1'b1, faultN)
    pIn <= 1'b0;
    cy(5);
    `CHK("absent", 1'b0, faultN)
    pIn <= 1'b1;
    cy(5);
    `CHK("grounded", 3'h7, cOe & ~cOut)
    axi(0, 8'h08, 0);
    `CHK("unmapped", 2'h2, r)
    axi(1, 8'h00, 1);
    axi(0, 8'h00, 0);
    `CHK("hold", 32'h1, q)
    axi(1, 8'h00, 0);
    x = xs(x);
    {s1, s2} <= x[1:0];
    reqN <= 1'b0;
    `WT(boost)
    `CHK("boostAt", 1'b1, t < 6)
    `WT(cOe == 3'h0)
    `CHK("unground", 1'b1, t < 3)
    cy(990);
    axi(0, 8'h04, 0);
    `CHK("clkEarly", 1'b0, q[7])
    `CHK("supplyOn", 1'b1, vcc)
    cy(40);
    axi(0, 8'h04, 0);
    `CHK("clkAt4T", 1'b1, q[7])
    per(p);
    `CHK("period", dv[x[1:0]] * 4, p)
    hRst <= 1'b1;
    cy(20);
    `CHK("rstHeld", 1'b0, cRst)
    `WT(cRst)
    `CHK("rstAt", 1'b1, t > 500 && t < 800)
    x = xs(x);
    {s1, s2} <= x[1:0];
    cy(100);
    per(p);
    `CHK("period2", dv[x[1:0]] * 4, p)
    hPull <= 1'b1;
    `WT(!cIn[0])
    `CHK("slaveLow", 1'b1, t > 19 && t < 30)
    hPull <= 1'b0;
    `WT(cOe[0] && cOut[0])
    `CHK("activeHigh", 1'b1, t < 30)
    cy(60);
    cPull <= 1'b1;
    `WT(hOe[0] && !hOut[0])
    `CHK("cardMaster", 1'b1, t < 30)
    cPull <= 1'b0;
    cy(60);
    reqN <= 1'b1;
    cy(6);
    `CHK("rstLow", 1'b0, cRst)
    `WT(!boost)
    `CHK("groundAt", 1'b1, t > 1240 && t < 1300)
    cy(2);
    `CHK("regrounded", 3'h7, cOe & ~cOut)
    `CHK("supplyOff", 1'b0, vcc)
    reqN <= 1'b0;
    `WT(boost)
    cy(1040);
    axi(0, 8'h04, 0);
    `CHK("clkHeld", 1'b0, q[7])
    hRst <= 1'b0;
    per(p);
    `CHK("period3", dv[x[1:0]] * 4, p)
    pIn <= 1'b0;
    cy(6);
    `CHK("faultOut", 1'b0, faultN)
    `WT(!boost)
    `CHK("emergencyAt", 1'b1, t > 1240 && t < 1300)
    cy(4);
    `CHK("faultKept", 1'b0, faultN)
    reqN <= 1'b1;
    cy(6);
    `CHK("absentOut", 1'b0, faultN)
    giveVerdict();
  end
endmodule : css_sequencer_bench
`default_nettype wire
